// [inc/swp_pkg.sv]
// ------------------------------------------------------------
// Behaviour
// RQ1: User buttons hold slots one/three, two/four
// RQ2: Shifted functions last only while shift held
// RQ3: Crosspoint n selects input n, shifted n+5
// RQ4: Menu pages or chroma marker make shortcuts
// RQ5: Dial edits blinking setting, hold restores default; code skips the default for network settings
// RQ6: Dial sets duration while transition button held
// RQ7: Long menu hold toggles menu and indicator
// RQ8: Fade indicator lit out, blinks in, off done
// RQ9: Cut runs transition, indicator lit meanwhile
// RQ10: Auto runs over duration, indicator lit meanwhile
// RQ11: Auto press halts run, next resumes remainder
// RQ12: Auto continues from midway lever position
// RQ13: Lever drives progress, takes over past progress
// RQ14: Mix weights always sum to full scale
// RQ15: Mix and wipe mutually exclusive with indicators
// RQ16: Dial steps wipe pattern while wipe held
// RQ17: Exactly one bus tally indicator lit
// RQ18: At most one delegation indicator lit
// RQ19: Delegation state chooses crosspoint target bus
// RQ20: Background rows feed bus A and B
// RQ21: Auxiliary A row picks outputs, B inputs
// RQ22: Picture in picture uses B row only
// RQ23: Buttons debounced, long hold classified
// ------------------------------------------------------------
package swp_pkg;
    localparam int NB = 25;
    localparam int B_USER = 0, B_SHIFT = 2, B_DIAL = 3, B_MENU = 4, B_PICTURE_IN_PICTURE = 5;
    localparam int B_KEY = 6, B_FTB = 7, B_CUT = 8, B_AUTO = 9, B_MIX = 10;
    localparam int B_WIPE = 11, B_DLG = 12, B_XA = 15, B_XB = 20;
    localparam int CLK_NS = 5;
    localparam int DEB_NS = 5_000_000;
    localparam int DEB_CYC = (DEB_NS + CLK_NS - 1) / CLK_NS;
    localparam int DEB_MS = 5;
    localparam int LONG_MS = 1000;
    localparam logic [7:0] LONG_TICKS = 8'(LONG_MS / DEB_MS);
    localparam int CUT_NS = 1000;
    localparam logic [7:0] CUT_CYC = 8'((CUT_NS + CLK_NS - 1) / CLK_NS);
    localparam int PW = 10;
    localparam logic [9:0] PMAX = 10'h3ff;
    localparam logic [15:0] DUR_RST = 16'h0040;
    localparam logic [7:0] R_CTRL = 8'h00, R_STAT = 8'h04, R_DUR = 8'h08, R_SRC = 8'h18;
    localparam logic [1:0] RSP_OK = 2'h0, RSP_ERR = 2'h2;
    localparam logic [1:0] BM_AB = 2'h0, BM_PGMA = 2'h1, BM_PGMB = 2'h2;
    localparam logic [2:0] PG_WIPE = 3'h2, PG_PICTURE_IN_PICTURE = 3'h3, PG_KEYADJ = 3'h5;
    localparam logic [3:0] SRC_OUT = 4'ha;
    localparam int D_AUTO = 0, D_FTB = 1, D_PICTURE_IN_PICTURE = 2, D_KEY = 3;

    typedef enum logic [2:0] {AT_IDLE = 3'b001, AT_RUN = 3'b010, AT_HOLD = 3'b100} swp_at_t;
    typedef enum logic [3:0] {
        FT_IDLE = 4'b0001, FT_OUT = 4'b0010, FT_BLACK = 4'b0100, FT_IN = 4'b1000
    } swp_ft_t;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } swp_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } swp_axi_rsp_t;

    typedef struct packed {
        logic       shift, onscreen_menu, picture_in_picture, key, fade_to_black, cut, auto_run, mix, wipe, tally_a, tally_b;
        logic [2:0] dlg;
        logic [4:0] xa, xb;
    } swp_led_t;

    typedef struct packed {
        logic       user_evt;
        logic [1:0] user_slot;
        logic       user_short, set_step, set_up, field_right, set_dflt;
        logic       menu_on, picture_in_picture_on, key_on, wipe_sel;
        logic [3:0] pattern;
        logic       on_air_b;
        logic [3:0] bus_a, bus_b, aux, pip, kfill, ksrc;
        logic [9:0] mix_wa, mix_wb, ftb_level;
    } swp_cmd_t;
endpackage : swp_pkg

// [verilog/swp_panel.sv]
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module swp_panel
    import swp_pkg::*;
#(
    parameter int P_DEB_CYC = DEB_CYC
)(
    // Clock and reset
    input  wire logic          i_clk,
    input  wire logic          i_arst_n,
    // Register bus
    input  wire swp_axi_req_t  i_axi,
    output      swp_axi_rsp_t  o_axi,
    // Panel controls
    input  wire logic [NB-1:0] i_btn,
    input  wire logic [PW-1:0] i_lever,
    input  wire logic          i_dial_step,
    input  wire logic          i_dial_up,
    // Menu context
    input  wire logic [2:0]    i_menu_page,
    input  wire logic          i_chroma_marker,
    input  wire logic          i_blinking,
    input  wire logic          i_net_setting,
    // Indicators and commands
    output      swp_led_t      o_led,
    output      swp_cmd_t      o_cmd
);
    typedef struct packed {
        logic [19:0]        tick;
        logic [NB-1:0]      samp, stab;
        logic [NB-1:0][7:0] hold;
        logic [5:0]         blink;
        logic [1:0]         bus_mode;
        swp_at_t            at;
        logic [PW-1:0]      prog, lev_last;
        logic               lev_dir;
        logic [15:0]        step, fstep;
        swp_ft_t            ft;
        logic [7:0]         cut;
        logic [3:0][15:0]   dur;
        logic               aw_ok, w_ok;
        logic [7:0]         awaddr;
        logic [31:0]        wdata;
        logic [3:0]         wstrb;
        swp_axi_rsp_t       rsp;
        swp_led_t           led;
        swp_cmd_t           cmd;
    } swp_state_t;

    swp_state_t    q, d;
    logic [NB-1:0] eq, nst, pr, lg, hl;
    logic          tick, shf, moved, takeover, done, cut_go;
    logic [PW-1:0] eff;

    function automatic logic [3:0] crosspoint_input(input int n, input logic s);
        crosspoint_input = 4'(n) + (s ? 4'h5 : 4'h0);
    endfunction : crosspoint_input

    function automatic logic [15:0] adj(input logic [15:0] v, input logic up);
        if (up)
            adj = (v == 16'hffff) ? v : v + 16'h1;
        else
            adj = (v == 16'h1) ? v : v - 16'h1;
    endfunction : adj

    function automatic logic [31:0] wmask(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        for (int b = 0; b < 4; b++)
            wmask[8*b+:8] = s[b] ? n[8*b+:8] : o[8*b+:8];
    endfunction : wmask

    // ------------------------------------------------------------
    // Button conditioning
    // ------------------------------------------------------------
    assign tick = q.tick == 20'(P_DEB_CYC - 1);
    assign eq = ~(q.samp ^ i_btn);
    assign nst = tick ? ((eq & i_btn) | (~eq & q.stab)) : q.stab; // see RQ23
    assign pr = nst & ~q.stab;
    assign shf = q.stab[B_SHIFT];
    assign eff = q.lev_dir ? PMAX - i_lever : i_lever;
    assign moved = i_lever != q.lev_last;
    assign takeover = moved && q.at != AT_IDLE && eff > q.prog; // see RQ13

    always_comb
    begin
        for (int i = 0; i < NB; i++)
        begin
            hl[i] = q.stab[i] && q.hold[i] == LONG_TICKS;
            lg[i] = tick && q.stab[i] && q.hold[i] == LONG_TICKS - 8'h01; // see RQ23
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        d = q;
        done = 1'b0;
        cut_go = 1'b0;
        d.cmd.user_evt = 1'b0;
        d.cmd.set_step = 1'b0;
        d.cmd.field_right = 1'b0;
        d.cmd.set_dflt = 1'b0;
        d.tick = tick ? 20'h0 : q.tick + 20'h1;
        d.stab = nst;
        if (tick)
        begin
            d.samp = i_btn;
            d.blink = q.blink + 6'h1;
        end
        for (int i = 0; i < NB; i++)
        begin
            if (!nst[i])
                d.hold[i] = 8'h0;
            else if (tick && q.hold[i] != LONG_TICKS)
                d.hold[i] = q.hold[i] + 8'h1;
        end
        // User buttons, shift picks the upper slot
        for (int u = 0; u < 2; u++)
        begin
            if (pr[B_USER + u])
            begin
                d.cmd.user_evt = 1'b1;
                d.cmd.user_slot = {shf, 1'(u)}; // see RQ1 see RQ2
                d.cmd.user_short = i_chroma_marker ||
                    i_menu_page inside {PG_WIPE, PG_PICTURE_IN_PICTURE, PG_KEYADJ}; // see RQ4
            end
        end
        if (lg[B_MENU])
            d.cmd.menu_on = !q.cmd.menu_on; // see RQ7
        // Dial
        if (i_dial_step)
        begin
            if (hl[B_AUTO])
                d.dur[D_AUTO] = adj(q.dur[D_AUTO], i_dial_up); // see RQ6
            else if (hl[B_FTB])
                d.dur[D_FTB] = adj(q.dur[D_FTB], i_dial_up);
            else if (hl[B_PICTURE_IN_PICTURE])
                d.dur[D_PICTURE_IN_PICTURE] = adj(q.dur[D_PICTURE_IN_PICTURE], i_dial_up);
            else if (hl[B_KEY])
                d.dur[D_KEY] = adj(q.dur[D_KEY], i_dial_up);
            else if (hl[B_WIPE])
                d.cmd.pattern = i_dial_up ? q.cmd.pattern + 4'h1
                                          : q.cmd.pattern - 4'h1; // see RQ16
            else if (i_blinking)
            begin
                d.cmd.set_step = 1'b1; // see RQ5
                d.cmd.set_up = i_dial_up;
            end
        end
        if (pr[B_DIAL] && i_blinking)
            d.cmd.field_right = 1'b1; // see RQ5
        if (lg[B_DIAL] && i_blinking && !i_net_setting)
            d.cmd.set_dflt = 1'b1; // see RQ5
        // Transition type and keyer switches
        if (pr[B_MIX])
            d.cmd.wipe_sel = 1'b0; // see RQ15
        else if (pr[B_WIPE])
            d.cmd.wipe_sel = 1'b1;
        if (pr[B_PICTURE_IN_PICTURE])
            d.cmd.picture_in_picture_on = !q.cmd.picture_in_picture_on;
        if (pr[B_KEY])
            d.cmd.key_on = !q.cmd.key_on;
        // Delegation: bit 0 aux, bit 1 picture in picture, bit 2 key
        for (int k = 0; k < 3; k++)
        begin
            if (pr[B_DLG + k])
                d.led.dlg = q.led.dlg[k] ? 3'h0 : 3'(1 << k); // see RQ18
        end
        // Crosspoint rows
        for (int n = 0; n < 5; n++)
        begin
            if (pr[B_XA + n])
            begin
                case (q.led.dlg) // see RQ19
                    3'h0: d.cmd.bus_a = crosspoint_input(n, shf); // see RQ3 see RQ20
                    3'h1: d.cmd.aux = SRC_OUT + 4'(n); // see RQ21
                    3'h4: d.cmd.ksrc = crosspoint_input(n, shf);
                    default: ;
                endcase
            end
            if (pr[B_XB + n])
            begin
                case (q.led.dlg)
                    3'h0: d.cmd.bus_b = crosspoint_input(n, shf); // see RQ20
                    3'h1: d.cmd.aux = crosspoint_input(n, shf); // see RQ21
                    3'h2: d.cmd.pip = crosspoint_input(n, shf); // see RQ22
                    3'h4: d.cmd.kfill = crosspoint_input(n, shf);
                    default: ;
                endcase
            end
        end
        // Transition engine
        d.lev_last = i_lever;
        if (takeover || (moved && q.at == AT_IDLE))
        begin
            d.at = AT_IDLE;
            d.prog = eff; // see RQ13
            d.step = 16'h0;
            if (eff == PMAX)
            begin
                done = 1'b1;
                d.lev_dir = !q.lev_dir;
            end
        end
        else
        begin
            case (q.at)
                AT_IDLE:
                    if (pr[B_AUTO])
                        d.at = AT_RUN; // see RQ10 see RQ12
                AT_RUN:
                begin
                    if (pr[B_AUTO])
                        d.at = AT_HOLD; // see RQ11
                    else if (q.step + 16'h1 >= q.dur[D_AUTO])
                    begin
                        d.step = 16'h0;
                        d.prog = q.prog + 10'h1; // see RQ10
                        if (q.prog == PMAX - 10'h1)
                            done = 1'b1;
                    end
                    else
                        d.step = q.step + 16'h1;
                end
                AT_HOLD:
                    if (pr[B_AUTO])
                        d.at = AT_RUN; // see RQ11
                default: d.at = AT_IDLE;
            endcase
        end
        if (pr[B_CUT] && q.cut == 8'h0 && q.at == AT_IDLE)
        begin
            cut_go = 1'b1;
            d.cut = CUT_CYC; // see RQ9
        end
        else if (q.cut != 8'h0)
        begin
            d.cut = q.cut - 8'h1;
            if (q.cut == 8'h1)
                done = 1'b1;
        end
        if (done)
        begin
            d.prog = 10'h0;
            d.at = AT_IDLE;
            d.step = 16'h0;
            if (q.bus_mode == BM_AB)
                d.cmd.on_air_b = !q.cmd.on_air_b;
            else
            begin
                d.cmd.bus_a = q.cmd.bus_b;
                d.cmd.bus_b = q.cmd.bus_a;
            end
        end
        // Fade to black
        case (q.ft)
            FT_IDLE:
                if (pr[B_FTB])
                    d.ft = FT_OUT;
            FT_OUT, FT_IN:
            begin
                if (q.fstep + 16'h1 >= q.dur[D_FTB])
                begin
                    d.fstep = 16'h0;
                    if (q.ft == FT_OUT)
                    begin
                        d.cmd.ftb_level = q.cmd.ftb_level + 10'h1;
                        if (q.cmd.ftb_level == PMAX - 10'h1)
                            d.ft = FT_BLACK; // see RQ8
                    end
                    else
                    begin
                        d.cmd.ftb_level = q.cmd.ftb_level - 10'h1;
                        if (q.cmd.ftb_level == 10'h1)
                            d.ft = FT_IDLE; // see RQ8
                    end
                end
                else
                    d.fstep = q.fstep + 16'h1;
            end
            FT_BLACK:
                if (pr[B_FTB])
                    d.ft = FT_IN;
            default: d.ft = FT_IDLE;
        endcase
        // Register bus
        d.rsp.bvalid = q.rsp.bvalid && !i_axi.bready;
        d.rsp.rvalid = q.rsp.rvalid && !i_axi.rready;
        if (i_axi.awvalid && q.rsp.awready)
        begin
            d.aw_ok = 1'b1;
            d.awaddr = i_axi.awaddr;
        end
        if (i_axi.wvalid && q.rsp.wready)
        begin
            d.w_ok = 1'b1;
            d.wdata = i_axi.wdata;
            d.wstrb = i_axi.wstrb;
        end
        if (q.aw_ok && q.w_ok && !q.rsp.bvalid)
        begin
            d.aw_ok = 1'b0;
            d.w_ok = 1'b0;
            d.rsp.bvalid = 1'b1;
            d.rsp.bresp = RSP_OK;
            case (q.awaddr)
                R_CTRL: d.bus_mode = 2'(wmask({30'h0, q.bus_mode}, q.wdata, q.wstrb));
                R_DUR, R_DUR + 8'h4, R_DUR + 8'h8, R_DUR + 8'hc:
                    d.dur[q.awaddr[3:2] + 2'h2] =
                        16'(wmask({16'h0, q.dur[q.awaddr[3:2] + 2'h2]}, q.wdata, q.wstrb));
                default: d.rsp.bresp = RSP_ERR;
            endcase
        end
        if (i_axi.arvalid && q.rsp.arready)
        begin
            d.rsp.rvalid = 1'b1;
            d.rsp.rresp = RSP_OK;
            case (i_axi.araddr)
                R_CTRL: d.rsp.rdata = {30'h0, q.bus_mode};
                R_STAT: d.rsp.rdata = {10'h0, q.ft, q.at, q.led.dlg, q.cmd.on_air_b,
                                       q.cmd.menu_on, q.prog};
                R_DUR, R_DUR + 8'h4, R_DUR + 8'h8, R_DUR + 8'hc:
                    d.rsp.rdata = {16'h0, q.dur[i_axi.araddr[3:2] + 2'h2]};
                R_SRC: d.rsp.rdata = {8'h0, q.cmd.ksrc, q.cmd.kfill, q.cmd.pip,
                                      q.cmd.aux, q.cmd.bus_b, q.cmd.bus_a};
                default:
                begin
                    d.rsp.rdata = 32'h0;
                    d.rsp.rresp = RSP_ERR;
                end
            endcase
        end
        d.rsp.arready = !d.rsp.rvalid;
        d.rsp.awready = !d.aw_ok && !d.rsp.bvalid;
        d.rsp.wready = !d.w_ok && !d.rsp.bvalid;
        // Indicators
        if (d.bus_mode != BM_AB)
            d.cmd.on_air_b = d.bus_mode == BM_PGMB;
        d.led.tally_b = d.cmd.on_air_b; // see RQ17
        d.led.tally_a = !d.cmd.on_air_b;
        d.led.shift = nst[B_SHIFT]; // see RQ2
        d.led.onscreen_menu = d.cmd.menu_on; // see RQ7
        d.led.picture_in_picture = d.cmd.picture_in_picture_on;
        d.led.key = d.cmd.key_on;
        d.led.fade_to_black = d.ft == FT_OUT || (d.ft == FT_IN && q.blink[5]); // see RQ8
        d.led.cut = d.cut != 8'h0; // see RQ9
        d.led.auto_run = d.at == AT_RUN; // see RQ10
        d.led.mix = !d.cmd.wipe_sel; // see RQ15
        d.led.wipe = d.cmd.wipe_sel;
        d.cmd.mix_wb = d.prog;
        d.cmd.mix_wa = PMAX - d.prog; // see RQ14
        for (int n = 0; n < 5; n++)
        begin
            case (d.led.dlg)
                3'h0:
                begin
                    d.led.xa[n] = d.cmd.bus_a == crosspoint_input(n, nst[B_SHIFT]);
                    d.led.xb[n] = d.cmd.bus_b == crosspoint_input(n, nst[B_SHIFT]);
                end
                3'h1:
                begin
                    d.led.xa[n] = d.cmd.aux == SRC_OUT + 4'(n);
                    d.led.xb[n] = d.cmd.aux == crosspoint_input(n, nst[B_SHIFT]);
                end
                3'h2:
                begin
                    d.led.xa[n] = 1'b0;
                    d.led.xb[n] = d.cmd.pip == crosspoint_input(n, nst[B_SHIFT]);
                end
                3'h4:
                begin
                    d.led.xa[n] = d.cmd.ksrc == crosspoint_input(n, nst[B_SHIFT]);
                    d.led.xb[n] = d.cmd.kfill == crosspoint_input(n, nst[B_SHIFT]);
                end
                default:
                begin
                    d.led.xa[n] = 1'b0;
                    d.led.xb[n] = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            q <= '0;
            q.at <= AT_IDLE;
            q.ft <= FT_IDLE;
            q.dur <= {4{DUR_RST}};
            q.bus_mode <= BM_PGMA;
            q.led.tally_a <= 1'b1;
            q.led.mix <= 1'b1;
            q.cmd.mix_wa <= PMAX;
        end
        else
        begin
            q <= d;
        end
    end

    assign o_axi = q.rsp;
    assign o_led = q.led;
    assign o_cmd = q.cmd;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    user_shift_a: assert property (pr[B_USER] && !pr[B_USER+1] && shf // see RQ1
        |=> q.cmd.user_evt && q.cmd.user_slot == 2'h2) else $error("Shifted slot wrong");
    xpt_plain_a: assert property (pr[B_XB] && !shf && q.led.dlg == 3'h0 && !done // see RQ2
        |=> q.cmd.bus_b == 4'h0) else $error("Unshifted crosspoint wrong");
    xpt_shift_a: assert property (pr[B_XB] && shf && q.led.dlg == 3'h0 && !done // see RQ3
        |=> q.cmd.bus_b == 4'h5) else $error("Shifted crosspoint wrong");
    user_short_a: assert property (pr[B_USER] && !pr[B_USER+1] && i_chroma_marker // see RQ4
        |=> q.cmd.user_short) else $error("Shortcut mode missed");
    dflt_net_a: assert property (lg[B_DIAL] && i_net_setting |=> !q.cmd.set_dflt) // see RQ5
        else $error("Network setting defaulted");
    osd_toggle_a: assert property (lg[B_MENU] |=> q.cmd.menu_on != $past(q.cmd.menu_on) // see RQ7
        && q.led.onscreen_menu == q.cmd.menu_on) else $error("Menu toggle wrong");
    ftb_led_a: assert property ((q.ft == FT_OUT |-> q.led.fade_to_black) and // see RQ8
        (q.ft inside {FT_IDLE, FT_BLACK} |-> !q.led.fade_to_black)) else $error("Fade indicator wrong");
    cut_swap_a: assert property (cut_go && q.bus_mode == BM_AB |=> q.led.cut // see RQ9
        ##200 !q.led.cut && q.cmd.on_air_b != $past(q.cmd.on_air_b, 200))
        else $error("Cut did not complete");
    auto_halt_a: assert property (q.at == AT_RUN && pr[B_AUTO] && !takeover && !done // see RQ11
        |=> q.at == AT_HOLD && !q.led.auto_run) else $error("Auto not halted");
    take_over_a: assert property (takeover |=> q.at == AT_IDLE) // see RQ13
        else $error("Lever did not take over");
    mix_sum_a: assert property (11'(q.cmd.mix_wa) + 11'(q.cmd.mix_wb) == 11'(PMAX)) // see RQ14
        else $error("Mix weights off");
    mix_excl_a: assert property (q.led.mix != q.led.wipe) // see RQ15
        else $error("Mix and wipe both set");
    tally_one_a: assert property ($onehot({q.led.tally_a, q.led.tally_b})) // see RQ17
        else $error("Tally not one-hot");
    deleg_one_a: assert property ($onehot0(q.led.dlg)) // see RQ18
        else $error("Two delegations lit");
    aux_out_a: assert property (pr[B_XA] && q.led.dlg == 3'h1 |=> q.cmd.aux == SRC_OUT) // see RQ21
        else $error("Aux output select wrong");

    auto_done_c: cover property (done && q.at == AT_RUN);
    fade_in_c: cover property (q.ft == FT_IN);
    lever_c: cover property (takeover);
    bad_addr_c: cover property (q.rsp.bvalid && q.rsp.bresp == RSP_ERR);
endmodule : swp_panel

// [tb/swp_operator.sv]
`timescale 1ns/1ps
module swp_operator
    import swp_pkg::*;
(
    // Clock
    input  wire logic          i_clk,
    // Panel buttons, high while pressed
    output      logic [NB-1:0] o_btn
);
    initial o_btn = '0;
    // Contacts chatter for a few cycles before they settle
    task automatic press(input int b, input int len);
        for (int k = 0; k < 6; k++)
        begin
            @(posedge i_clk);
            o_btn[b] <= k[0];
        end
        repeat (len) @(posedge i_clk);
        o_btn[b] <= 1'b0;
        repeat (24) @(posedge i_clk);
    endtask : press
    task automatic hold(input int b, input logic lv);
        @(posedge i_clk);
        o_btn[b] <= lv;
        repeat (12) @(posedge i_clk);
    endtask : hold
endmodule : swp_operator

// [tb/switcher_panel_control_logic_tb.sv]
`timescale 1ns/1ps
module switcher_panel_control_logic_tb
    import swp_pkg::*;
;
    typedef struct {int id; logic [31:0] e;} swp_note_t;
    logic          i_clk = 1'b0, i_arst_n = 1'b0, look = 1'b0;
    logic          chroma = 1'b0, blink = 1'b0, netset = 1'b0, sc;
    logic          dstep = 1'b0, dup = 1'b0;
    logic [PW-1:0] lever = '0;
    logic [2:0]    page = '0;
    swp_axi_req_t  ax = '{wstrb: 4'hf, bready: 1'b1, rready: 1'b1, default: '0};
    swp_axi_rsp_t  ar;
    swp_led_t      led;
    swp_cmd_t      cmd;
    logic [NB-1:0] btn;
    logic [31:0]   seen;
    swp_note_t     cur, notes[$];
    int            error_cnt = 0, checked = 0, sh;
    string         nm[11] = '{"tally", "bus_a", "bus_b", "aux", "dlg", "cut", "auto", "menu",
                              "mixsum", "rdata", "user"};
    always #2.5 i_clk = ~i_clk;
    swp_panel #(.P_DEB_CYC(4)) DUT (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_axi(ax),
        .o_axi(ar), .i_btn(btn), .i_lever(lever), .i_dial_step(dstep), .i_dial_up(dup),
        .i_menu_page(page), .i_chroma_marker(chroma), .i_blinking(blink),
        .i_net_setting(netset), .o_led(led), .o_cmd(cmd));
    swp_operator u_op (.i_clk(i_clk), .o_btn(btn));
    always @(posedge i_clk)
    begin
        if (look || ar.rvalid)
        begin
            cur = notes.pop_front();
            case (cur.id)
                0: seen = {28'h0, led.tally_a, led.tally_b, led.mix, led.wipe};
                1: seen = 32'(cmd.bus_a);
                2: seen = 32'(cmd.bus_b);
                3: seen = 32'(cmd.aux);
                4: seen = 32'(led.dlg);
                5: seen = 32'(led.cut);
                6: seen = 32'(led.auto_run);
                7: seen = {30'h0, led.onscreen_menu, cmd.menu_on};
                8: seen = 32'(cmd.mix_wa) + 32'(cmd.mix_wb);
                10: seen = {29'h0, cmd.user_slot, cmd.user_short};
                default: seen = {ar.rresp, ar.rdata[29:0]};
            endcase
            checked++;
            if (seen !== cur.e)
            begin
                error_cnt++;
                $display("BAD %s expected %h seen %h", nm[cur.id], cur.e, seen);
            end
        end
    end
    task automatic note(input int id, input logic [31:0] e);
        notes.push_back('{id, e});
        @(posedge i_clk);
        look <= 1'b1;
        @(posedge i_clk);
        look <= 1'b0;
    endtask : note
    task automatic pc(input int b, input int id, input logic [31:0] e);
        u_op.press(b, 24);
        note(id, e);
    endtask : pc
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit ta = 0, tw = 0;
        @(posedge i_clk);
        ax.awvalid <= 1'b1;
        ax.awaddr <= a;
        ax.wvalid <= 1'b1;
        ax.wdata <= d;
        while (!(ta && tw))
        begin
            @(posedge i_clk);
            ta = ta | ar.awready;
            tw = tw | ar.wready;
            ax.awvalid <= !ta;
            ax.wvalid <= !tw;
        end
        do @(posedge i_clk); while (!ar.bvalid);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        notes.push_back('{9, e});
        @(posedge i_clk);
        ax.arvalid <= 1'b1;
        ax.araddr <= a;
        do @(posedge i_clk); while (!ar.arready);
        ax.arvalid <= 1'b0;
        do @(posedge i_clk); while (!ar.rvalid);
    endtask : rd
    task automatic complete_run;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run
    initial
    begin
        repeat (60000) @(posedge i_clk);
        error_cnt++;
        complete_run();
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        void'($urandom(97));
        repeat (10) @(posedge i_clk);
        i_arst_n <= 1'b1;
        page <= 3'($urandom);
        chroma <= 1'($urandom);
        blink <= 1'($urandom);
        netset <= 1'($urandom);
        repeat (2) @(posedge i_clk);
        note(0, 32'ha);
        note(8, 32'd1023);
        rd(R_CTRL, 32'h1);
        rd(8'h40, 32'h80000000);
        rd(R_DUR, 32'(DUR_RST));
        for (int k = 0; k < 5; k++)
        begin
            sh = $urandom % 2;
            u_op.hold(B_SHIFT, sh[0]);
            pc(B_XA + k, 1, k + 5 * sh);
            pc(B_XB + k, 2, k + 5 * sh);
            u_op.hold(B_SHIFT, 1'b0);
            pc(B_XB + k, 2, k);
        end
        sc = chroma || page inside {PG_WIPE, PG_PICTURE_IN_PICTURE, PG_KEYADJ};
        u_op.hold(B_SHIFT, 1'b1);
        pc(B_USER, 10, {29'h0, 2'h2, sc});
        u_op.hold(B_SHIFT, 1'b0);
        pc(B_USER + 1, 10, {29'h0, 2'h1, sc});
        pc(B_WIPE, 0, 32'h9);
        pc(B_MIX, 0, 32'ha);
        pc(B_DLG, 4, 32'h1);
        for (int k = 0; k < 5; k++)
            pc(B_XA + k, 3, 10 + k);
        pc(B_XB + 2, 3, 2);
        pc(B_DLG, 4, 0);
        pc(B_DLG + 1, 4, 2);
        pc(B_DLG + 2, 4, 4);
        pc(B_DLG + 2, 4, 0);
        wr(R_CTRL, 32'h0);
        rd(R_CTRL, 32'h0);
        pc(B_CUT, 5, 1);
        repeat (250) @(posedge i_clk);
        note(5, 0);
        note(0, 32'h6);
        wr(R_DUR, 32'h1);
        pc(B_AUTO, 6, 1);
        pc(B_AUTO, 6, 0);
        repeat (300) @(posedge i_clk);
        note(0, 32'h6);
        note(8, 32'd1023);
        pc(B_AUTO, 6, 1);
        for (int t = 0; t < 3000 && led.auto_run !== 1'b0; t++)
            @(posedge i_clk);
        note(0, 32'ha);
        lever <= PMAX;
        note(0, 32'h6);
        u_op.hold(B_PICTURE_IN_PICTURE, 1'b1);
        repeat (820) @(posedge i_clk);
        dstep <= 1'b1;
        dup <= 1'b1;
        @(posedge i_clk);
        dstep <= 1'b0;
        u_op.hold(B_PICTURE_IN_PICTURE, 1'b0);
        rd(R_DUR + 8'h8, 32'(DUR_RST) + 32'h1);
        u_op.press(B_MENU, 900);
        note(7, 3);
        u_op.press(B_MENU, 900);
        note(7, 0);
        complete_run();
    end
endmodule : switcher_panel_control_logic_tb
